// *** src/down_timer.sv ***
// Purpose: Loadable down counter stepped by a tick enable.
// Assumes: Load wins over a tick in the same cycle.
// Notes:   Busy is high while the count is nonzero.
`timescale 1ns/1ps
module down_timer #(
   parameter int W = 16
) (
   input  wire logic         i_clk,   // core clock
   input  wire logic         i_rst,   // synchronous reset
   input  wire logic         i_start, // load the count
   input  wire logic [W-1:0] i_load,  // count in ticks
   input  wire logic         i_tick,  // step enable
   output logic              o_busy   // count still running
);
   logic [W-1:0] cnt;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt <= '0;
      end else if (i_start) begin
         cnt <= i_load;
      end else if (i_tick && cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign o_busy = (cnt != '0);
endmodule

// *** src/servo_stop_brake_sequencer.sv ***
// Purpose: Stop method, holding brake and vibration supervision sequencer.
// Assumes: Speed, vibration and amplitude inputs are magnitudes, synchronous.
// Notes:   Registers answer one cycle after a request; unmapped reads zero.
`timescale 1ns/1ps
module servo_stop_brake_sequencer
   import stop_brake_pkg::*;
#(
   parameter int MS_DIV  = CYC_PER_MS,
   parameter int IDX_DIV = CYC_PER_IDX
) (
   input  wire logic        I_CORE_CLK,       // 250 MHz core clock
   input  wire logic        I_RST,            // synchronous reset, high
   input  wire logic        I_WB_CYC,         // bus cycle
   input  wire logic        I_WB_STB,         // bus strobe
   input  wire logic        I_WB_WE,          // write enable
   input  wire logic [7:0]  I_WB_ADR,         // byte address
   input  wire logic [31:0] I_WB_DAT,         // write data
   input  wire logic [3:0]  I_WB_SEL,         // byte enables
   output logic      [31:0] O_WB_DAT,         // read data
   output logic             O_WB_ACK,         // acknowledge
   input  wire logic        I_SERVO_ON,       // enable command level
   input  wire logic        I_FAULT_ONE,      // class-one fault level
   input  wire logic        I_FAULT_TWO,      // class-two fault level
   input  wire logic        I_FORCED_STOP,    // forced stop level
   input  wire logic        I_OVERTRAVEL,     // overtravel level
   input  wire logic [15:0] I_SPEED_RPM,      // speed magnitude
   input  wire logic [15:0] I_VIB_LEVEL,      // vibration speed
   input  wire logic [15:0] I_VIB_REFERENCE,  // vibration reference
   input  wire logic [15:0] I_RESID_AMP,      // residual amplitude
   input  wire logic [15:0] I_POS_DONE_THR,   // completion threshold
   input  wire logic        I_ENC_INDEX,      // raw index pulse
   output logic             O_MOTOR_ENERGISE, // power stage on
   output logic             O_DYNAMIC_BRAKE,  // dynamic brake on
   output logic             O_BRAKE_ENGAGE,   // holding brake engaged
   output logic             O_SERVO_LOCK,     // hold position stopped
   output logic             O_CMD_ACCEPT,     // commands accepted
   output logic             O_DECEL_TORQUE,   // torque deceleration
   output logic             O_DECEL_TIMED,    // timed deceleration
   output logic      [15:0] O_STOP_TORQUE,    // decel torque, percent
   output logic      [15:0] O_STOP_TIME,      // decel time, ms
   output logic             O_VIB_WARNING,    // vibration warning
   output logic             O_VIB_ALARM,      // vibration alarm
   output logic             O_RESID_VIB,      // residual vibration high
   output logic             O_INDEX_PULSE,    // shaped index pulse
   output logic             O_IRQ             // interrupt level
);

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   function automatic logic [15:0] sat(input logic [31:0] v,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
      logic [15:0] r;
      r = v[15:0];
      if (v < {16'h0000, lo}) begin
         r = lo;
      end else if (v > {16'h0000, hi}) begin
         r = hi;
      end
      return r;
   endfunction

   logic [15:0]        cfg [CFG_NUM];
   logic [IRQ_NUM-1:0] irq_stat;
   logic [IRQ_NUM-1:0] irq_ev;
   seq_state_t         state;
   seq_state_t         next_state;

   wire        req      = I_WB_CYC && I_WB_STB;
   wire        wr       = req && I_WB_WE && O_WB_ACK;
   wire [5:0]  word_idx = I_WB_ADR[7:2];
   wire        cfg_hit  = (I_WB_ADR[1:0] == 2'b00)
                       && (word_idx < 6'(CFG_NUM));
   wire [31:0] sel_mask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                           {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
   wire [15:0] cfg_old  = cfg_hit ? cfg[word_idx[3:0]] : 16'h0000;
   wire [31:0] wr_word  = (I_WB_DAT & sel_mask)
                        | ({16'h0000, cfg_old} & ~sel_mask);
   wire [31:0] status_w = {16'h0000, 4'(state), 4'h0, O_MOTOR_ENERGISE,
                           O_BRAKE_ENGAGE, O_DYNAMIC_BRAKE, O_CMD_ACCEPT,
                           O_VIB_WARNING, O_VIB_ALARM, O_RESID_VIB,
                           O_SERVO_LOCK};
   wire [31:0] rd_word  = cfg_hit ? {16'h0000, cfg_old}
                        : (I_WB_ADR == ADR_STATUS) ? status_w
                        : (I_WB_ADR == ADR_IRQ_STAT)
                          ? {27'h0, irq_stat} : 32'h0000_0000;
   wire        irq_clr_hit = wr && (I_WB_ADR == ADR_IRQ_STAT)
                          && I_WB_SEL[0];

   // Stop nibbles are capped one by one, other words by their range.
   wire [15:0] stop_w = {4'(sat({28'h0, wr_word[15:12]}, 16'h0, 16'h2)),
                         4'(sat({28'h0, wr_word[11:8]}, 16'h0, 16'h4)),
                         4'(sat({28'h0, wr_word[7:4]}, 16'h0, 16'h2)),
                         4'(sat({28'h0, wr_word[3:0]}, 16'h0, 16'h2))};

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
      end else begin
         O_WB_ACK <= req && !O_WB_ACK;
         if (req && !O_WB_ACK) begin
            O_WB_DAT <= rd_word;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      for (int i = 0; i < CFG_NUM; i++) begin
         if (I_RST) begin
            cfg[i] <= CFG_RST[i];
         end else if (wr && cfg_hit && word_idx == 6'(i)) begin
            cfg[i] <= (i == CFG_STOP) ? stop_w
                      : sat(wr_word, CFG_MIN[i], CFG_MAX[i]);
         end
      end
   end

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~(irq_clr_hit ? I_WB_DAT[IRQ_NUM-1:0]
                      : '0)) | irq_ev;
      end
   end

   assign O_IRQ = |(irq_stat & cfg[CFG_IRQ_MASK][IRQ_NUM-1:0]);

   // ------------------------------------------------------------
   // Field decode
   // ------------------------------------------------------------
   wire [1:0]  vib_sel    = cfg[CFG_VIB_SEL][1:0];
   wire [1:0]  basic_sel  = cfg[CFG_STOP][STOP_BASIC_LSB +: 2];
   wire [1:0]  two_sel    = cfg[CFG_STOP][STOP_TWO_LSB +: 2];
   wire [2:0]  ot_sel     = cfg[CFG_STOP][STOP_OT_LSB +: 3];
   wire [1:0]  force_sel  = cfg[CFG_STOP][STOP_FORCE_LSB +: 2];
   wire        standstill = (I_SPEED_RPM == 16'h0000);

   assign O_STOP_TORQUE = cfg[CFG_DEC_TORQUE];
   assign O_STOP_TIME   = cfg[CFG_DEC_TIME];

   // ------------------------------------------------------------
   // Vibration supervision
   // ------------------------------------------------------------
   wire [31:0] vib_scaled = {16'h0000, I_VIB_LEVEL} * 32'd100;
   wire [31:0] vib_limit  = {16'h0000, I_VIB_REFERENCE}
                          * {16'h0000, cfg[CFG_VIB_SENS]};
   wire        vib_det    = (I_VIB_LEVEL >= cfg[CFG_VIB_BASE])
                         && (vib_scaled >= vib_limit);
   wire [31:0] resid_sc   = {16'h0000, I_RESID_AMP} * 32'd1000;
   wire [31:0] resid_lim  = {16'h0000, I_POS_DONE_THR}
                          * {16'h0000, cfg[CFG_RESID_LIM]};
   wire        resid_det  = resid_sc > resid_lim;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_VIB_WARNING <= 1'b0;
         O_VIB_ALARM   <= 1'b0;
         O_RESID_VIB   <= 1'b0;
      end else begin
         O_VIB_WARNING <= vib_det && (vib_sel == 2'd1);
         O_VIB_ALARM   <= vib_det && (vib_sel == 2'd2);
         O_RESID_VIB   <= resid_det;
      end
   end

   // ------------------------------------------------------------
   // Stop cause selection
   // ------------------------------------------------------------
   // Class one and servo off take the basic stop at once, except from coast, which goes straight to off.
   wire hard_stop  = I_FAULT_ONE || !I_SERVO_ON;
   wire two_dec    = I_FAULT_TWO && two_sel != 2'd0;
   wire force_dec  = I_FORCED_STOP && force_sel != 2'd0;
   wire ot_dec     = I_OVERTRAVEL && ot_sel != 3'd0;
   wire any_cause  = hard_stop || I_FAULT_TWO || I_FORCED_STOP
                  || I_OVERTRAVEL;
   wire basic_now  = hard_stop
                  || (I_FAULT_TWO && two_sel == 2'd0)
                  || (!I_FAULT_TWO && I_FORCED_STOP && force_sel == 2'd0)
                  || (!I_FAULT_TWO && !I_FORCED_STOP && I_OVERTRAVEL
                      && ot_sel == 3'd0);
   wire use_torque = two_dec ? (two_sel == 2'd1)
                   : force_dec ? (force_sel == 2'd1)
                   : (ot_sel == 3'd1 || ot_sel == 3'd2);
   wire ot_only    = !I_FAULT_TWO && !I_FORCED_STOP && ot_dec;
   wire ot_lock    = ot_sel == 3'd1 || ot_sel == 3'd3;
   wire stop_state = standstill ? 1'b1 : 1'b0;

   logic dec_torque;
   logic dec_ot;
   logic dec_lock;

   // ------------------------------------------------------------
   // Sequence timing
   // ------------------------------------------------------------
   logic        ms_tick;
   logic        seq_busy;
   wire         seq_start = (next_state != state);
   wire [15:0]  arm_dly   = (cfg[CFG_OPEN_DLY] > cfg[CFG_STATIC_DLY])
                          ? cfg[CFG_OPEN_DLY] : cfg[CFG_STATIC_DLY];
   wire [15:0]  seq_load  = (next_state == ST_ARM) ? arm_dly
                          : (next_state == ST_HOLD) ? cfg[CFG_STATIC_DLY]
                          : (next_state == ST_SPIN) ? cfg[CFG_ROT_WAIT]
                          : (next_state == ST_DECEL) ? cfg[CFG_DEC_TIME]
                          : 16'h0000;

   tick_div #(.DIV(MS_DIV)) u_ms_tick (
      .i_clk  (I_CORE_CLK),
      .i_rst  (I_RST),
      .i_clr  (seq_start),
      .o_tick (ms_tick)
   );

   down_timer #(.W(16)) u_seq_timer (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_RST),
      .i_start (seq_start),
      .i_load  (seq_load),
      .i_tick  (ms_tick),
      .o_busy  (seq_busy)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Basic stop splits on motion: brake at once when stationary,
   // otherwise wait for low speed while the motor runs down.
   wire [3:0] basic_next = stop_state ? 4'(ST_HOLD) : 4'(ST_SPIN);

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (!any_cause) begin
               next_state = ST_ARM;
            end
         end
         ST_ARM, ST_RUN, ST_LOCK: begin
            if (basic_now) begin
               next_state = seq_state_t'(basic_next);
            end else if (state == ST_LOCK && (I_FAULT_TWO || I_FORCED_STOP)) begin
               next_state = seq_state_t'(basic_next);
            end else if (state == ST_LOCK) begin
               next_state = I_OVERTRAVEL ? ST_LOCK : ST_RUN;
            end else if (two_dec || force_dec || ot_dec) begin
               next_state = ST_DECEL;
            end else if (state == ST_ARM && !seq_busy) begin
               next_state = ST_RUN;
            end
         end
         ST_DECEL: begin
            if (hard_stop) begin
               next_state = seq_state_t'(basic_next);
            end else if (standstill || (!dec_torque && !seq_busy)) begin
               if (!dec_ot) begin
                  next_state = seq_state_t'(basic_next);
               end else begin
                  next_state = dec_lock ? ST_LOCK : ST_COAST;
               end
            end
         end
         ST_COAST: begin
            if (!I_OVERTRAVEL || hard_stop) begin
               next_state = ST_OFF;
            end
         end
         ST_HOLD: begin
            if (!seq_busy) begin
               next_state = ST_OFF;
            end
         end
         ST_SPIN: begin
            if (I_SPEED_RPM < cfg[CFG_ROT_THR] || !seq_busy) begin
               next_state = ST_OFF;
            end
         end
         default: next_state = ST_OFF;
      endcase
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state      <= ST_OFF;
         dec_torque <= 1'b0;
         dec_ot     <= 1'b0;
         dec_lock   <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == ST_DECEL && state != ST_DECEL) begin
            dec_torque <= use_torque;
            dec_ot     <= ot_only;
            dec_lock   <= ot_lock;
         end
      end
   end

   // ------------------------------------------------------------
   // Drive outputs
   // ------------------------------------------------------------
   wire de_energised = (state == ST_OFF) || (state == ST_SPIN)
                    || (state == ST_COAST);

   assign O_MOTOR_ENERGISE = !de_energised;
   assign O_BRAKE_ENGAGE   = (state == ST_OFF) || (state == ST_HOLD);
   assign O_SERVO_LOCK     = (state == ST_LOCK);
   assign O_CMD_ACCEPT     = (state == ST_RUN);
   assign O_DECEL_TORQUE   = (state == ST_DECEL) && dec_torque;
   assign O_DECEL_TIMED    = (state == ST_DECEL) && !dec_torque;

   // Dynamic brake is held by 0, dropped at standstill by 1, never by 2.
   assign O_DYNAMIC_BRAKE  = (state == ST_OFF || state == ST_SPIN)
                          && (basic_sel == 2'd0
                              || (basic_sel == 2'd1 && !standstill));

   wire run_like = (state == ST_RUN) || (state == ST_ARM)
                || (state == ST_LOCK);
   assign irq_ev = {(next_state == ST_RUN) && (state != ST_RUN),
                    run_like && seq_start && next_state != ST_RUN
                    && next_state != ST_LOCK,
                    resid_det && !O_RESID_VIB,
                    vib_det && (vib_sel == 2'd2) && !O_VIB_ALARM,
                    vib_det && (vib_sel == 2'd1) && !O_VIB_WARNING};

   // ------------------------------------------------------------
   // Index pulse shaping
   // ------------------------------------------------------------
   logic idx_tick;
   logic idx_busy;

   tick_div #(.DIV(IDX_DIV)) u_idx_tick (
      .i_clk  (I_CORE_CLK),
      .i_rst  (I_RST),
      .i_clr  (I_ENC_INDEX),
      .o_tick (idx_tick)
   );

   down_timer #(.W(16)) u_idx_timer (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_RST),
      .i_start (I_ENC_INDEX),
      .i_load  (cfg[CFG_IDX_WIDTH]),
      .i_tick  (idx_tick),
      .o_busy  (idx_busy)
   );

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_INDEX_PULSE <= 1'b0;
      end else begin
         O_INDEX_PULSE <= (cfg[CFG_IDX_WIDTH] == 16'h0000)
                          ? I_ENC_INDEX : idx_busy;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_vib_off_quiet: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      $past(vib_sel) == 2'd0 |-> !O_VIB_WARNING && !O_VIB_ALARM)
      else $error("vibration flagged while detection is off");
   a_vib_alarm_cause: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      vib_det && vib_sel == 2'd2 |=> O_VIB_ALARM && !O_VIB_WARNING)
      else $error("vibration alarm missing in alarm mode");
   a_sens_in_range: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      cfg[CFG_VIB_SENS] >= 16'd50 && cfg[CFG_VIB_SENS] <= 16'd500)
      else $error("sensitivity left its range");
   a_coast_no_db: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      basic_sel == 2'd2 |-> !O_DYNAMIC_BRAKE)
      else $error("dynamic brake used in coast mode");
   a_decel_one_mode: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state == ST_DECEL |-> O_DECEL_TORQUE != O_DECEL_TIMED)
      else $error("deceleration mode ambiguous");
   a_accept_after_arm: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      $rose(O_CMD_ACCEPT) |-> $past(state) == ST_LOCK
         || ($past(state) == ST_ARM && !$past(seq_busy)))
      else $error("commands accepted before delay ended");
   a_hold_energised: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state == ST_HOLD |-> O_BRAKE_ENGAGE && O_MOTOR_ENERGISE)
      else $error("hold lost brake or power");
   a_spin_threshold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      state == ST_SPIN && I_SPEED_RPM < cfg[CFG_ROT_THR] |=> O_BRAKE_ENGAGE)
      else $error("brake late below speed threshold");
   a_wb_ack_next: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      req && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
      else $error("bus answer not one cycle long");
endmodule

// *** src/stop_brake_pkg.sv ***
// Purpose: Shared constants and types of the stop and brake sequencer.
// Assumes: 250 MHz core clock, 32-bit classic Wishbone register port.
// Notes:   Configuration words sit at byte offset four times their index.
package stop_brake_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 4;
   localparam int MS_TICK_NS     = 1_000_000;
   localparam int IDX_TICK_NS    = 100_000;
   localparam int CYC_PER_MS     = MS_TICK_NS / CLK_PERIOD_NS;
   localparam int CYC_PER_IDX    = IDX_TICK_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int CFG_NUM        = 13;
   localparam int CFG_VIB_SEL    = 0;
   localparam int CFG_VIB_SENS   = 1;
   localparam int CFG_VIB_BASE   = 2;
   localparam int CFG_RESID_LIM  = 3;
   localparam int CFG_STOP       = 4;
   localparam int CFG_DEC_TORQUE = 5;
   localparam int CFG_DEC_TIME   = 6;
   localparam int CFG_OPEN_DLY   = 7;
   localparam int CFG_STATIC_DLY = 8;
   localparam int CFG_ROT_THR    = 9;
   localparam int CFG_ROT_WAIT   = 10;
   localparam int CFG_IDX_WIDTH  = 11;
   localparam int CFG_IRQ_MASK   = 12;
   localparam logic [7:0] ADR_STATUS   = 8'h34;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h38;

   localparam logic [15:0] CFG_MIN [CFG_NUM] = '{16'h0000, 16'h0032,
      16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] CFG_MAX [CFG_NUM] = '{16'h0002, 16'h01F4,
      16'h1388, 16'h0BB8, 16'h3432, 16'h015E, 16'hEA60, 16'h01F4,
      16'h01F4, 16'h1770, 16'h03E8, 16'h03E8, 16'h001F};
   localparam logic [15:0] CFG_RST [CFG_NUM] = '{16'h0000, 16'h0064,
      16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // Stop configuration nibble positions.
   localparam int STOP_BASIC_LSB = 0;
   localparam int STOP_TWO_LSB   = 4;
   localparam int STOP_OT_LSB    = 8;
   localparam int STOP_FORCE_LSB = 12;

   // Interrupt status bits.
   localparam int IRQ_NUM       = 5;
   localparam int IRQ_VIB_WARN  = 0;
   localparam int IRQ_VIB_ALARM = 1;
   localparam int IRQ_RESID     = 2;
   localparam int IRQ_STOP      = 3;
   localparam int IRQ_READY     = 4;

   typedef enum logic [3:0] {
      ST_OFF, ST_ARM, ST_RUN, ST_DECEL, ST_LOCK, ST_COAST, ST_HOLD, ST_SPIN
   } seq_state_t;

endpackage

// *** src/tick_div.sv ***
// Purpose: Divides the core clock into a one-cycle tick enable.
// Assumes: Clear restarts the period so a delay starts on a whole tick.
// Notes:   First tick comes DIV cycles after clear.
`timescale 1ns/1ps
module tick_div #(
   parameter int DIV = 250000
) (
   input  wire logic i_clk,  // core clock
   input  wire logic i_rst,  // synchronous reset
   input  wire logic i_clr,  // restart the period
   output logic      o_tick  // one-cycle tick
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt;
   wire          wrap = (cnt == W'(DIV - 1));

   always_ff @(posedge i_clk) begin
      if (i_rst || i_clr || wrap) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   assign o_tick = wrap && !i_clr;
endmodule

// *** test/motor_model.sv ***
// Purpose: Shaft model that feeds speed back to the stop sequencer.
// Assumes: Speed falls one rpm a cycle while decelerating or unpowered.
// Notes:   The bench loads a speed to start a rotating case.
`timescale 1ns/1ps
module motor_model (
   input  wire logic        i_clk,   // core clock
   input  wire logic        i_load,  // load a new speed
   input  wire logic [15:0] i_set,   // speed to load
   input  wire logic        i_power, // motor energised
   input  wire logic        i_decel, // deceleration requested
   output logic      [15:0] o_speed  // speed magnitude
);
   initial o_speed = 16'h0000;
   always @(posedge i_clk) begin
      if (i_load) begin
         o_speed <= i_set;
      end else if ((i_decel || !i_power) && o_speed != 16'h0000) begin
         o_speed <= o_speed - 16'h0001;
      end
   end
endmodule

// *** test/servo_stop_brake_sequencer_tb.sv ***
// Purpose: Self-checking bench of the stop and brake sequencer.
// Assumes: Millisecond divider shortened to ten cycles.
// Notes:   Residual and overtravel inputs stay low.
`timescale 1ns/1ps
module servo_stop_brake_sequencer_tb;
   import stop_brake_pkg::*;
   logic        clk = 0, rst = 1, cyc = 0, we = 0, son = 0, f1 = 0;
   logic        fs = 0, ld = 0, ack, en, brk, acc, dtq, dtm, vw, irq;
   logic        f2 = 0, idx = 0, db, ipl;
   logic [3:0]  sel = 4'hF;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, rd, q;
   logic [15:0] vib = 16'h0000, vref = 16'h000A, sset = 16'h0000, spd, stt;
   int          n_mismatch = 0, check_count = 0, cyc_n = 0;
   servo_stop_brake_sequencer #(.MS_DIV(10), .IDX_DIV(4))
      i_servo_stop_brake_sequencer (
      .I_CORE_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(cyc),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wd), .I_WB_SEL(sel),
      .O_WB_DAT(rd), .O_WB_ACK(ack), .I_SERVO_ON(son), .I_FAULT_ONE(f1),
      .I_FAULT_TWO(f2), .I_FORCED_STOP(fs), .I_OVERTRAVEL(1'b0),
      .I_SPEED_RPM(spd), .I_VIB_LEVEL(vib), .I_VIB_REFERENCE(vref),
      .I_RESID_AMP(16'h0000), .I_POS_DONE_THR(16'h0000), .I_ENC_INDEX(idx),
      .O_MOTOR_ENERGISE(en), .O_DYNAMIC_BRAKE(db), .O_BRAKE_ENGAGE(brk),
      .O_SERVO_LOCK(), .O_CMD_ACCEPT(acc), .O_DECEL_TORQUE(dtq),
      .O_DECEL_TIMED(dtm), .O_STOP_TORQUE(), .O_STOP_TIME(stt),
      .O_VIB_WARNING(vw), .O_VIB_ALARM(), .O_RESID_VIB(),
      .O_INDEX_PULSE(ipl), .O_IRQ(irq));
   motor_model i_motor_model (.i_clk(clk), .i_load(ld), .i_set(sset),
      .i_power(en), .i_decel(dtq || dtm), .o_speed(spd));
   initial forever #2 clk = ~clk;
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Caller enters right after a rising edge; one idle cycle follows.
   // Waits for the answer however long it takes; only the timeout ends it.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rd;
      cyc <= 0;
      @(posedge clk);
   endtask
   task t_regs;
      wb(0, 8'h04, 0); chk("sens reset", q, 32'h64);
      wb(1, 8'h04, 32'h10); wb(0, 8'h04, 0); chk("sens min", q, 32'h32);
      wb(1, 8'h00, 32'h3); wb(0, 8'h00, 0); chk("vib sel max", q, 32'h2);
      wb(0, 8'h3C, 0); chk("unmapped", q, 32'h0);
   endtask
   task t_vib;
      wb(1, 8'h00, 32'h1); vib <= 16'h0005; repeat (3) @(posedge clk);
      chk("warn at limit", vw, 1'b1);
      vib <= 16'h0004; repeat (3) @(posedge clk);
      chk("warn below", vw, 1'b0);
   endtask
   task t_enable;
      wb(1, 8'h1C, 32'h1); wb(1, 8'h20, 32'h1); wb(1, 8'h30, 32'h10);
      son <= 1; repeat (5) @(posedge clk);
      chk("accept early", acc, 1'b0);
      repeat (10) @(posedge clk);
      chk("accept late", acc, 1'b1);
      chk("ready irq", irq, 1'b1);
      wb(1, 8'h38, 32'h10); chk("irq cleared", irq, 1'b0);
   endtask
   task t_stop;
      wb(1, 8'h10, 32'h1000); sset <= 16'h0014; ld <= 1; fs <= 1;
      @(posedge clk); ld <= 0; repeat (3) @(posedge clk);
      chk("torque decel", dtq, 1'b1);
      repeat (40) @(posedge clk);
      chk("decel done", dtq, 1'b0);
      fs <= 0; repeat (30) @(posedge clk);
      son <= 0; repeat (3) @(posedge clk);
      chk("hold brake", brk, 1'b1);
      chk("hold power", en, 1'b1);
      repeat (20) @(posedge clk);
      chk("power off", en, 1'b0);
   endtask
   // Timed stop ends on its timer long before the shaft reaches zero.
   task t_two;
      wb(1, 8'h18, 32'h2); wb(1, 8'h10, 32'h20);
      son <= 1; repeat (15) @(posedge clk);
      chk("rearm", acc, 1'b1);
      chk("decel time", stt, 32'h2);
      sset <= 16'h0064; ld <= 1; f2 <= 1;
      @(posedge clk); ld <= 0; repeat (3) @(posedge clk);
      chk("timed decel", dtm, 1'b1);
      chk("no torque", dtq, 1'b0);
      repeat (25) @(posedge clk);
      chk("timed end", dtm, 1'b0);
      chk("basic off", en, 1'b0);
      chk("db held", db, 1'b1);
      f2 <= 0; son <= 0;
   endtask
   // Width zero passes the raw pulse; otherwise four cycles per step.
   task t_index;
      int n;
      for (int w = 0; w < 3; w += 2) begin
         wb(1, 8'h2C, w); idx <= 1; @(posedge clk); idx <= 0; n = 0;
         repeat (20) begin
            @(posedge clk);
            if (ipl === 1'b1) n++;
         end
         chk("index width", n, (w == 0) ? 1 : w * 4);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_regs();
      t_vib();
      t_enable();
      t_stop();
      t_two();
      t_index();
      wrap_up();
   end
endmodule
